// ### design/sfpw_core.sv
// flash program, erase and burst-wrap command sequencer
`timescale 1ns/1ps
module sfpw_core #(
  parameter int PROG_CYCLES  = sfpw_pkg::PROG_CYCLES_DFLT,
  parameter int ERASE_CYCLES = sfpw_pkg::ERASE_CYCLES_DFLT
) (
  // core clock and reset
  input  wire logic                        core_clk_i,
  input  wire logic                        reset_n_i,
  // serial link
  input  wire logic                        link_clk_i,
  input  wire logic                        chip_sel_n_i,
  input  wire logic [3:0]                  quad_data_lines_i,
  // configuration from the status logic
  input  wire logic                        quad_enable_bit_i,
  input  wire logic                        quad_command_mode_i,
  input  wire logic                        addr_4byte_i,
  input  wire logic [4:0]                  block_protect_bits_i,
  // status
  output logic                             busy_flag_o,
  output logic                             write_latch_o,
  output logic                             wrap_enable_o,
  output logic [1:0]                       wrap_length_o,
  // array port
  output logic                             mem_wr_o,
  output logic                             mem_erase_o,
  output logic                             mem_erase_32k_o,
  output logic [sfpw_pkg::ADDR_W-1:0]      mem_addr_o,
  output logic [7:0]                       mem_data_o,
  // read address stepping
  input  wire logic                        rd_wrap_read_i,
  input  wire logic [sfpw_pkg::ADDR_W-1:0] rd_addr_i,
  output logic [sfpw_pkg::ADDR_W-1:0]      rd_next_addr_o
);
  import sfpw_pkg::*;

  if (PROG_CYCLES <= PAGE_BYTES + 1 || PROG_CYCLES >= 2**TMR_W ||
      ERASE_CYCLES < 2 || ERASE_CYCLES >= 2**TMR_W) begin : g_bad_cycles
    $error("sfpw_core: cycle counts out of range");
  end

  // ---------------- link domain ----------------
  typedef struct packed {
    logic [1:0] qe_s;
    logic [1:0] qpi_s;
    logic [2:0] bits;
    logic [3:0] nb;
    logic [7:0] cmd;
    logic [7:0] sh;
    logic [7:0] byte_q;
    logic       byte_tgl;
    logic       mid_tgl;
  } sfpw_link_t;

  sfpw_link_t lk;
  sfpw_link_t next_lk;
  logic       fresh;

  // select high between frames marks the next edge as a frame's first
  always_ff @(posedge link_clk_i or posedge chip_sel_n_i) begin
    if (chip_sel_n_i) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  always_comb begin
    logic       quad;
    logic [2:0] bits;
    logic [3:0] nb;
    logic [2:0] bits_n;
    quad    = 1'b0;
    bits    = fresh ? 3'h0 : lk.bits;
    nb      = fresh ? 4'h0 : lk.nb;
    bits_n  = 3'h0;
    next_lk = lk;
    // mode flags advance only on link edges; the host must flush a change with a frame
    next_lk.qe_s  = {lk.qe_s[0], quad_enable_bit_i};
    next_lk.qpi_s = {lk.qpi_s[0], quad_command_mode_i};
    // quad program moves address and data four bits a clock
    quad = lk.qpi_s[1] | ((nb != 4'h0) && (lk.cmd == CMD_QPP) && lk.qe_s[1]);
    next_lk.sh = quad ? {lk.sh[3:0], quad_data_lines_i} : {lk.sh[6:0], quad_data_lines_i[0]};
    bits_n = quad ? bits + 3'h4 : bits + 3'h1;
    next_lk.bits = bits_n;
    next_lk.nb   = nb;
    if (bits_n == 3'h0) begin
      next_lk.byte_q   = next_lk.sh;
      next_lk.byte_tgl = ~lk.byte_tgl;
      if (nb == 4'h0) begin
        next_lk.cmd = next_lk.sh;
      end
      if (nb != 4'hf) begin
        next_lk.nb = nb + 4'h1;
      end
    end else begin
      next_lk.mid_tgl = ~lk.mid_tgl;
    end
  end

  always_ff @(posedge link_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lk <= '0;
    end else begin
      lk <= next_lk;
    end
  end

  // ---------------- core domain ----------------
  typedef struct packed {
    logic [2:0]  cs_y;
    logic [2:0]  by_y;
    logic [2:0]  md_y;
    sfpw_state_t st;
    logic [7:0]  cmd;
    logic [3:0]  nb;
    logic [31:0] addr;
    logic [23:0] page;
    logic [7:0]  ptr;
    logic [7:0]  lastb;
    logic        has_data;
    logic        partial;
    logic        wl;
    logic        wdis;
    logic [1:0]  wlen;
    logic [255:0] valid;
    logic [8:0]  idx;
    logic [23:0] tmr;
    logic        mem_wr;
    logic        mem_erase;
    logic        mem_e32;
    logic [31:0] mem_addr;
    logic [7:0]  mem_data;
    logic [31:0] rd_next;
  } sfpw_core_t;

  sfpw_core_t c;
  sfpw_core_t next_c;
  logic [7:0] page_buf [PAGE_BYTES];
  logic       buf_we;
  logic [7:0] buf_wa;

  function automatic logic is_prot(input logic [31:0] a, input logic [4:0] bp);
    logic [3:0] sh;
    logic [9:0] lim;
    sh  = (bp > 5'h0a) ? PROT_ALL_SH : 4'(bp - 5'h01);
    lim = BLK64_COUNT - (10'h001 << sh);
    is_prot = (bp != 5'h00) && ({1'b0, a[MEM_AW-1:BLK64_LSB]} >= lim);
  endfunction : is_prot

  always_comb begin
    logic [2:0]  ab;
    logic        endf;
    logic        whole;
    logic        idle;
    logic        prot;
    logic        act;
    logic [31:0] msk;
    logic [31:0] inc;
    ab     = addr_4byte_i ? ADDR_BYTES4 : ADDR_BYTES3;
    endf   = c.cs_y[1] & ~c.cs_y[2];
    whole  = 1'b0;
    idle   = (c.st == ST_IDLE);
    prot   = 1'b0;
    act    = 1'b0;
    msk    = 32'h0;
    inc    = 32'h0;
    buf_we = 1'b0;
    buf_wa = c.ptr;
    next_c = c;
    next_c.cs_y = {c.cs_y[1], c.cs_y[0], chip_sel_n_i};
    next_c.by_y = {c.by_y[1], c.by_y[0], lk.byte_tgl};
    next_c.md_y = {c.md_y[1], c.md_y[0], lk.mid_tgl};
    next_c.mem_wr    = 1'b0;
    next_c.mem_erase = 1'b0;
    if (!c.cs_y[1] && c.cs_y[2]) begin
      // an empty frame must not act on the previous frame's command
      next_c.cmd      = 8'h00;
      next_c.nb       = 4'h0;
      next_c.addr     = 32'h0;
      next_c.has_data = 1'b0;
      next_c.partial  = 1'b0;
      if (idle) begin
        next_c.valid = '0;
      end
    end
    if (c.md_y[1] ^ c.md_y[2]) begin
      next_c.partial = 1'b1;
    end
    // the link holds byte_q steady until its next byte, long after the toggle lands
    if (c.by_y[1] ^ c.by_y[2]) begin
      next_c.partial = 1'b0;
      next_c.lastb   = lk.byte_q;
      if (c.nb == 4'h0) begin
        next_c.cmd = lk.byte_q;
      end else if (c.nb <= {1'b0, ab}) begin
        next_c.addr = {c.addr[23:0], lk.byte_q};
        next_c.ptr  = lk.byte_q;
      end else begin
        next_c.has_data = 1'b1;
        if (idle && (c.cmd == CMD_PP || c.cmd == CMD_QPP)) begin
          buf_we             = 1'b1;
          next_c.valid[c.ptr] = 1'b1;
          next_c.ptr         = c.ptr + 8'h01;
        end
      end
      if (c.nb != 4'hf) begin
        next_c.nb = c.nb + 4'h1;
      end
    end
    whole = ~next_c.partial;
    prot  = is_prot(next_c.addr, block_protect_bits_i);
    if (endf) begin
      case (next_c.cmd)
        CMD_WRITE_ENABLE_CMD: begin
          if (whole && next_c.nb == 4'h1 && idle) begin
            next_c.wl = 1'b1;
          end
        end
        CMD_WRDI: begin
          if (whole && next_c.nb == 4'h1 && idle) begin
            next_c.wl = 1'b0;
          end
        end
        CMD_WRAP: begin
          if (whole && next_c.nb == WRAP_CMD_LEN && !quad_command_mode_i) begin
            next_c.wdis = next_c.lastb[WRAP_DIS_BIT];
            next_c.wlen = next_c.lastb[WRAP_LEN_LSB+:2];
          end
        end
        CMD_RDPAR: begin
          if (whole && next_c.nb == RDPAR_CMD_LEN && quad_command_mode_i) begin
            next_c.wlen = next_c.lastb[PAR_LEN_LSB+:2];
          end
        end
        CMD_PP, CMD_QPP: begin
          if (whole && next_c.has_data && c.wl && idle && !prot &&
              (next_c.cmd != CMD_QPP || quad_enable_bit_i)) begin
            next_c.st   = ST_PROG;
            next_c.wl   = 1'b0;
            next_c.page = next_c.addr[31:8];
            next_c.idx  = 9'h000;
            next_c.tmr  = 24'h0;
          end
        end
        CMD_SE, CMD_BE32: begin
          if (whole && next_c.nb == {1'b0, ab} + 4'h1 && c.wl && idle &&
              !prot) begin
            next_c.st        = ST_ERASE;
            next_c.wl        = 1'b0;
            next_c.tmr       = 24'h0;
            next_c.mem_erase = 1'b1;
            next_c.mem_e32   = (next_c.cmd == CMD_BE32);
            next_c.mem_addr  = next_c.addr &
                               ~((next_c.cmd == CMD_BE32) ? BLK32_MASK : SECTOR_MASK);
          end
        end
        default: begin
        end
      endcase
    end
    case (c.st)
      ST_PROG: begin
        next_c.tmr = c.tmr + 24'h1;
        if (!c.idx[8]) begin
          next_c.mem_wr   = c.valid[c.idx[7:0]];
          next_c.mem_addr = {c.page, c.idx[7:0]};
          next_c.mem_data = page_buf[c.idx[7:0]];
          next_c.idx      = c.idx + 9'h001;
        end
        if (c.tmr == 24'(PROG_CYCLES - 1)) begin
          next_c.st = ST_IDLE;
        end
      end
      ST_ERASE: begin
        next_c.tmr = c.tmr + 24'h1;
        if (c.tmr == 24'(ERASE_CYCLES - 1)) begin
          next_c.st = ST_IDLE;
        end
      end
      default: begin
      end
    endcase
    // wrapped reads stay inside an aligned 8 to 64 byte section
    act = rd_wrap_read_i && (quad_command_mode_i || !c.wdis);
    msk = (WRAP_BASE << c.wlen) - 32'h1;
    inc = rd_addr_i + 32'h1;
    next_c.rd_next = act ? ((rd_addr_i & ~msk) | (inc & msk)) : inc;
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      c      <= '0;
      c.cs_y <= 3'h7;
      c.wdis <= WRAP_DIS_RST;
      c.wlen <= WRAP_LEN_RST;
    end else begin
      c <= next_c;
    end
  end

  // buffer holds no control state, so it needs no reset
  always_ff @(posedge core_clk_i) begin
    if (buf_we) begin
      page_buf[buf_wa] <= lk.byte_q;
    end
  end

  assign busy_flag_o     = (c.st != ST_IDLE);
  assign write_latch_o   = c.wl;
  assign wrap_enable_o   = ~c.wdis;
  assign wrap_length_o   = c.wlen;
  assign mem_wr_o        = c.mem_wr;
  assign mem_erase_o     = c.mem_erase;
  assign mem_erase_32k_o = c.mem_e32;
  assign mem_addr_o      = c.mem_addr;
  assign mem_data_o      = c.mem_data;
  assign rd_next_addr_o  = c.rd_next;

  // ---------------- checks ----------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  logic frame_end;
  assign frame_end = c.cs_y[1] & ~c.cs_y[2];

  sequence s_cycle_start;
    frame_end ##1 $rose(busy_flag_o);
  endsequence

  chk_start_needs_latch: assert property ($rose(busy_flag_o) |-> $past(c.wl))
    else $error("cycle started without write latch");
  chk_latch_drops: assert property (s_cycle_start |-> !write_latch_o)
    else $error("write latch not cleared at cycle start");
  chk_busy_holds: assert property (s_cycle_start |=> busy_flag_o [*8])
    else $error("busy dropped early");
  chk_prog_whole: assert property (
      $rose(busy_flag_o) && c.st == ST_PROG |-> $past(!c.partial))
    else $error("program started on partial byte");
  chk_quad_enable: assert property (
      $rose(busy_flag_o) && c.cmd == CMD_QPP |-> quad_enable_bit_i)
    else $error("quad program without quad enable");
  chk_sector_align: assert property (
      mem_erase_o && !mem_erase_32k_o |-> mem_addr_o[11:0] == 12'h0)
    else $error("sector erase address unaligned");
  chk_idle_on_busy: assert property (busy_flag_o && frame_end |=> !mem_erase_o)
    else $error("erase accepted while busy");
  chk_wrap_update: assert property (frame_end && next_c.cmd == CMD_WRAP &&
      next_c.nb == WRAP_CMD_LEN && !next_c.partial && !quad_command_mode_i
      |=> wrap_enable_o == !$past(next_c.lastb[WRAP_DIS_BIT]))
    else $error("wrap bits not taken");
  chk_rd_section: assert property ($past(rd_wrap_read_i) && !$past(c.wdis) &&
      !$past(quad_command_mode_i) |-> rd_next_addr_o[31:6] == $past(rd_addr_i[31:6]))
    else $error("wrapped read left its section");
endmodule : sfpw_core

// ### design/sfpw_pkg.sv
// constants and types for the flash program, erase and burst-wrap sequencer
package sfpw_pkg;
  // command codes
  localparam logic [7:0] CMD_WRITE_ENABLE_CMD  = 8'h06;
  localparam logic [7:0] CMD_WRDI  = 8'h04;
  localparam logic [7:0] CMD_WRAP  = 8'h77;
  localparam logic [7:0] CMD_RDPAR = 8'hc0;
  localparam logic [7:0] CMD_PP    = 8'h02;
  localparam logic [7:0] CMD_QPP   = 8'h32;
  localparam logic [7:0] CMD_SE    = 8'h20;
  localparam logic [7:0] CMD_BE32  = 8'h52;
  // address layout
  localparam int          ADDR_W      = 32;
  localparam logic [2:0]  ADDR_BYTES3 = 3'h3;
  localparam logic [2:0]  ADDR_BYTES4 = 3'h4;
  localparam int          PAGE_BYTES  = 256;
  localparam logic [31:0] SECTOR_MASK = 32'h0000_0fff;
  localparam logic [31:0] BLK32_MASK  = 32'h0000_7fff;
  localparam int          MEM_AW      = 25;
  localparam int          BLK64_LSB   = 16;
  localparam logic [9:0]  BLK64_COUNT = 10'h200;
  localparam logic [3:0]  PROT_ALL_SH = 4'h9;
  // wrap byte and read-parameter fields
  localparam int          WRAP_DIS_BIT  = 4;
  localparam int          WRAP_LEN_LSB  = 5;
  localparam int          PAR_LEN_LSB   = 0;
  localparam logic [31:0] WRAP_BASE     = 32'h0000_0008;
  localparam logic        WRAP_DIS_RST  = 1'b1;
  localparam logic [1:0]  WRAP_LEN_RST  = 2'h0;
  localparam logic [3:0]  WRAP_CMD_LEN  = 4'h5;
  localparam logic [3:0]  RDPAR_CMD_LEN = 4'h2;
  // self-timed cycles
  localparam int CLK_NS             = 10;
  localparam int PROG_TIME_NS       = 400000;
  localparam int ERASE_TIME_NS      = 4000000;
  localparam int PROG_CYCLES_DFLT   = PROG_TIME_NS / CLK_NS;
  localparam int ERASE_CYCLES_DFLT  = ERASE_TIME_NS / CLK_NS;
  localparam int TMR_W              = 24;

  typedef enum logic [1:0] {ST_IDLE, ST_PROG, ST_ERASE} sfpw_state_t;
endpackage : sfpw_pkg

// ### tb/sfpw_host_model.sv
// host controller model that drives the serial link frames
`timescale 1ns/1ps
module sfpw_host_model (
  // link outputs
  output logic       link_clk_o,
  output logic       chip_sel_n_o,
  output logic [3:0] data_o
);
  logic [7:0] buf_q [$];

  initial begin
    link_clk_o   = 1'b0;
    chip_sel_n_o = 1'b1;
    data_o       = 4'h0;
  end

  // the clock stands still between frames
  task automatic tick(input logic [3:0] v);
    data_o = v;
    #62.5 link_clk_o = 1'b1;
    #62.5 link_clk_o = 1'b0;
  endtask : tick

  // bytes from index qf on go out as nibbles, high first; extra bits tear the last byte
  task automatic send(input int qf, input int extra);
    chip_sel_n_o = 1'b0;
    #62.5;
    foreach (buf_q[i]) begin
      if (i >= qf) begin
        tick(buf_q[i][7:4]);
        tick(buf_q[i][3:0]);
      end else begin
        for (int b = 7; b >= 0; b--) tick({3'h0, buf_q[i][b]});
      end
    end
    for (int b = 0; b < extra; b++) tick(4'h5);
    #62.5 chip_sel_n_o = 1'b1;
    // released lines no longer show the last value
    data_o = ~data_o;
  endtask : send
endmodule : sfpw_host_model

// ### tb/tb_sfpw_core.sv
// self-checking bench for the program, erase and wrap sequencer
`timescale 1ns/1ps
module tb_sfpw_core;
  import sfpw_pkg::*;
  localparam int PROG_N  = 300;
  localparam int ERASE_N = 50;
  logic              core_clk_i, reset_n_i, link_clk, chip_sel_n;
  logic [3:0]        data_l;
  logic              quad_en, quad_mode, addr4, rd_wrap;
  logic [4:0]        bp;
  logic              busy, wlatch, wrap_en, mem_wr, mem_er, mem_er32, er32;
  logic [1:0]        wrap_len;
  logic [ADDR_W-1:0] mem_addr, rd_addr, rd_next, er_addr;
  logic [7:0]        mem_data;
  logic [7:0]        mem [logic [31:0]];
  int                err_count, compares, wr_n, er_n, wr_base;

  sfpw_host_model host (.link_clk_o(link_clk), .chip_sel_n_o(chip_sel_n), .data_o(data_l));

  sfpw_core #(.PROG_CYCLES(PROG_N), .ERASE_CYCLES(ERASE_N)) dut (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .link_clk_i(link_clk),
    .chip_sel_n_i(chip_sel_n), .quad_data_lines_i(data_l), .quad_enable_bit_i(quad_en),
    .quad_command_mode_i(quad_mode), .addr_4byte_i(addr4), .block_protect_bits_i(bp),
    .busy_flag_o(busy), .write_latch_o(wlatch), .wrap_enable_o(wrap_en),
    .wrap_length_o(wrap_len), .mem_wr_o(mem_wr), .mem_erase_o(mem_er),
    .mem_erase_32k_o(mem_er32), .mem_addr_o(mem_addr), .mem_data_o(mem_data),
    .rd_wrap_read_i(rd_wrap), .rd_addr_i(rd_addr), .rd_next_addr_o(rd_next));

  always #5 core_clk_i = ~core_clk_i;

  // array port monitor
  always @(posedge core_clk_i) begin
    if (mem_wr === 1'b1) begin
      mem[mem_addr] = mem_data;
      wr_n++;
    end
    if (mem_er === 1'b1) begin
      er_n++;
      er_addr = mem_addr;
      er32 = mem_er32;
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict;
    if (err_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  // command is seen and busy risen well within eight core cycles of select rise
  task automatic frame(input int qf, input int extra);
    host.send(qf, extra);
    repeat (8) @(posedge core_clk_i);
    #1;
  endtask : frame

  task automatic write_enable_cmd;
    host.buf_q = '{CMD_WRITE_ENABLE_CMD};
    frame(1000, 0);
  endtask : write_enable_cmd

  // the link learns a mode change two link edges late; an empty, torn frame flushes it
  task automatic set_mode(input logic q);
    quad_mode = q;
    host.buf_q = '{8'h00};
    frame(q ? 0 : 1000, 0);
  endtask : set_mode

  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0) begin
      @(posedge core_clk_i);
      #1;
      n++;
      if (n > PROG_N + 20) begin
        err_count++;
        print_verdict();
      end
    end
    repeat (4) @(posedge core_clk_i);
    #1;
  endtask : wait_idle

  task automatic step(input logic [31:0] a, input logic [31:0] exp);
    rd_addr = a;
    @(posedge core_clk_i);
    #1;
    check(rd_next, exp);
  endtask : step

  initial begin
    core_clk_i = 1'b0;
    reset_n_i  = 1'b0;
    {quad_en, quad_mode, addr4, rd_wrap} = 4'h0;
    bp = 5'h00;
    rd_addr = '0;
    {err_count, compares} = '0;
    wr_base = 0;
    repeat (3) @(posedge core_clk_i);
    #1 reset_n_i = 1'b1;
    repeat (4) @(posedge core_clk_i);
    #1;
    check(busy, 0);
    check({wrap_en, wrap_len}, 0);
    host.buf_q = '{CMD_WRAP, 8'h00, 8'h00, 8'h00, 8'h40};
    frame(1000, 0);
    check({wrap_en, wrap_len}, 3'h6);
    rd_wrap = 1'b1;
    step(32'h0000_013f, 32'h0000_0120);
    step(32'h0000_0125, 32'h0000_0126);
    set_mode(1'b1);
    host.buf_q = '{CMD_RDPAR, 8'h01};
    frame(0, 0);
    check(wrap_len, 1);
    step(32'h0000_013f, 32'h0000_0130);
    set_mode(1'b0);
    host.buf_q = '{CMD_WRAP, 8'h00, 8'h00, 8'h00, 8'h70};
    frame(1000, 0);
    check({wrap_en, wrap_len}, 3'h3);
    step(32'h0000_013f, 32'h0000_0140);
    rd_wrap = 1'b0;
    host.buf_q = '{CMD_PP, 8'h00, 8'h01, 8'hfe, 8'ha1};
    frame(1000, 0);
    check({busy, 28'(wr_n)}, 0);
    write_enable_cmd();
    check(wlatch, 1);
    host.buf_q = '{CMD_PP, 8'h00, 8'h01, 8'hfe, 8'ha1, 8'hb2, 8'hc3};
    frame(1000, 0);
    check({busy, wlatch}, 2'h2);
    write_enable_cmd();
    check(wlatch, 0);
    wait_idle();
    check(wr_n, 3);
    check({mem[32'h1fe], mem[32'h1ff]}, 16'ha1b2);
    check(mem[32'h100], 8'hc3);
    write_enable_cmd();
    host.buf_q = '{CMD_PP, 8'h00, 8'h00, 8'h10, 8'h11};
    frame(1000, 3);
    check({busy, wlatch}, 2'h1);
    host.buf_q = '{CMD_QPP, 8'h00, 8'h02, 8'h00, 8'h11};
    frame(1, 0);
    check(busy, 0);
    quad_en = 1'b1;
    host.buf_q = '{CMD_QPP, 8'h00, 8'h02, 8'h00};
    for (int i = 0; i < 256; i++) host.buf_q.push_back(8'(i));
    host.buf_q.push_back(8'h5a);
    wr_base = wr_n;
    frame(1, 0);
    check(busy, 1);
    wait_idle();
    check(wr_n - wr_base, 256);
    check({mem[32'h200], mem[32'h201], mem[32'h2ff]}, 24'h5a01ff);
    write_enable_cmd();
    host.buf_q = '{CMD_SE, 8'h01, 8'h23, 8'h45};
    frame(1000, 0);
    check({busy, er32, er_addr}, {2'h2, 32'h0001_2000});
    wait_idle();
    write_enable_cmd();
    host.buf_q = '{CMD_BE32, 8'h01, 8'h23, 8'h45};
    frame(1000, 0);
    check({busy, er32, er_addr}, {2'h3, 32'h0001_0000});
    wait_idle();
    write_enable_cmd();
    host.buf_q = '{CMD_SE, 8'h01, 8'h23, 8'h45, 8'h00};
    frame(1000, 0);
    check({busy, 28'(er_n)}, 2);
    addr4 = 1'b1;
    bp = 5'h01;
    host.buf_q = '{CMD_SE, 8'h01, 8'hff, 8'h00, 8'h00};
    frame(1000, 0);
    check(busy, 0);
    host.buf_q = '{CMD_BE32, 8'h01, 8'hff, 8'h80, 8'h00};
    frame(1000, 0);
    check(busy, 0);
    host.buf_q = '{CMD_PP, 8'h01, 8'hff, 8'hff, 8'h00, 8'h11};
    frame(1000, 0);
    check(busy, 0);
    host.buf_q = '{CMD_SE, 8'h01, 8'h00, 8'h00, 8'h00};
    frame(1000, 0);
    check({busy, er_addr, 28'(er_n)}, {1'b1, 32'h0100_0000, 28'h3});
    wait_idle();
    print_verdict();
  end
endmodule : tb_sfpw_core
